// file: rtl/wdx_core.sv
// executor for word decrement, unsigned divide, counted loop and irq gate
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RULE_01] word decrement treats even byte and next byte as one 16-bit value
// [RULE_02] word decrement sets zero, sign, overflow; carry, decimal, half kept
// [RULE_03] word decrement is two bytes, 8 cycles, opcodes 80 pair, 81 pointer
// [RULE_04] software should test zero by ORing result bytes, not zero flag
// [RULE_05] irq-off instruction clears mode bit 0, stopping all servicing
// [RULE_06] while disabled, requests still set pending bits, none serviced
// [RULE_07] irq-off, irq-on and loop instructions leave every flag unchanged
// [RULE_08] software should disable servicing before touching irq setup registers
// [RULE_09] divide 16-bit by 8-bit unsigned; quotient low byte, remainder high
// [RULE_10] overflow on quotient >= 256 or zero divisor; carry for 256..511
// [RULE_11] zero for zero divisor or quotient, sign from quotient msb
// [RULE_12] divide takes 10 cycles with zero divisor, else 26
// [RULE_13] divide is three bytes: 94 register, 95 indirect, 96 literal source
// [RULE_14] loop decrements working register, branches while result nonzero
// [RULE_15] loop displacement is signed, added to address after the instruction
// [RULE_16] software should bank the loop counter within 0c0h to 0cfh
// [RULE_17] loop is two bytes, opcode rA, 8 cycles taken or not
// [RULE_18] irq-on instruction sets mode bit 0, enabling servicing
// [RULE_19] pending request held while disabled is serviced after irq-on
// [RULE_20] irq-on is one byte, opcode 9f, 4 cycles
// [RULE_21] pointer word decrement takes even address from the working register
module wdx_core #(
  parameter int NUM_IRQ = 8
) (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               RST_B,
  // ahb-lite slave
  input  wire logic               HSEL,
  input  wire logic [31:0]        HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [31:0]        HWDATA,
  input  wire logic               HREADY,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  output logic [31:0]             HRDATA,
  // interrupt gate
  input  wire logic [NUM_IRQ-1:0] IRQ_REQ,
  output logic                    IRQ_SERVICE,
  output logic                    IRQ_GLOBAL_EN,
  // execution status
  output logic                    BUSY
);
  import wdx_pkg::*;

  // bus phase state
  logic               wr_pend_reg;
  logic               rd_wait_reg;
  logic               addr_ok_reg;
  logic [11:0]        bus_addr_reg;
  logic [31:0]        hrdata_reg;
  logic [31:0]        rd_mux;
  logic               accept;
  logic               wr_sys;
  // architectural state
  logic [7:0]         rf_reg [0:RF_DEPTH-1];
  logic [15:0]        pc_reg;
  wdx_flags_t         flags_reg;
  logic               irq_en_reg;
  logic [7:0]         bank_reg;
  logic [NUM_IRQ-1:0] pend_reg;
  logic [NUM_IRQ-1:0] pend_clr;
  // execution state
  wdx_state_t         state_reg;
  wdx_instr_t         instr_reg;
  logic               go_reg;
  logic               bad_reg;
  logic [4:0]         cnt_reg;
  logic [4:0]         n_cyc;
  logic               busy;
  logic               commit;
  // operand decode
  wdx_op_t            op;
  logic [7:0]         loop_addr;
  logic [7:0]         loop_val;
  logic [7:0]         div_src;
  logic [7:0]         dst_addr;
  logic [7:0]         dst_lo;
  logic [15:0]        pair;
  logic               div_zero;
  // unit results
  logic [15:0]        dec_word;
  logic               dec_z;
  logic               dec_s;
  logic               dec_v;
  logic [15:0]        quot;
  logic [7:0]         rem;
  logic               div_v;
  logic               div_c;
  logic               div_z;

  // window of the register file sits at 0x400..0x7fc, one byte per word
  function automatic logic rf_hit(input logic [11:0] a);
    rf_hit = (a[11:10] == RF_WIN_TAG);
  endfunction : rf_hit

  assign accept  = HSEL & HTRANS[1] & HREADY;
  assign busy    = go_reg | (state_reg != ST_IDLE);
  assign commit  = (state_reg == ST_COMMIT);
  assign wr_sys  = wr_pend_reg & addr_ok_reg;

  // address phase capture; reads get one wait state so data is a flop
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend_reg  <= 1'b0;
      rd_wait_reg  <= 1'b0;
      addr_ok_reg  <= 1'b0;
      bus_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= accept & HWRITE;
      rd_wait_reg <= accept & ~HWRITE;
      if (accept) begin
        addr_ok_reg  <= (HADDR[31:12] == 20'h00000);
        bus_addr_reg <= HADDR[11:0];
      end
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ok_reg && rf_hit(bus_addr_reg)) begin
      rd_mux[7:0] = rf_reg[bus_addr_reg[9:2]];
    end else if (addr_ok_reg) begin
      case (bus_addr_reg)
        ADDR_INSTR: rd_mux[23:0] = instr_reg;
        ADDR_STATUS: begin
          rd_mux[STAT_BUSY_BIT] = busy;
          rd_mux[STAT_BAD_BIT]  = bad_reg;
        end
        ADDR_MODE: begin
          rd_mux[MODE_EN_BIT]        = irq_en_reg;
          rd_mux[MODE_BANK_LSB +: 8] = bank_reg;
        end
        ADDR_PC: begin
          rd_mux[PC_LSB +: 16]   = pc_reg;
          rd_mux[FLAGS_LSB +: 8] = flags_reg;
        end
        ADDR_PEND: rd_mux[NUM_IRQ-1:0] = pend_reg;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // read data is loaded in the wait cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_wait_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  assign HREADYOUT = ~rd_wait_reg;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_reg;

  // instruction write launches execution; dropped while busy
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      instr_reg <= '0;
      go_reg    <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (wr_sys && bus_addr_reg == ADDR_INSTR && !busy) begin
        instr_reg <= HWDATA[23:0];
        go_reg    <= 1'b1;
      end
    end
  end

  // operand fetch straight from the register file; bus writes to it are
  // blocked while busy, so the operands stay put until commit
  always_comb begin
    op        = op_class(instr_reg.opc);
    // [RULE_14] counter register select
    loop_addr = work_addr(bank_reg, instr_reg.opc[7:4]);
    loop_val  = rf_reg[loop_addr] - 8'h01;
    // [RULE_13] divide source modes
    case (instr_reg.opc)
      OPC_DIV_REG: div_src = rf_reg[instr_reg.b1];
      OPC_DIV_IND: div_src = rf_reg[rf_reg[instr_reg.b1]];
      default:     div_src = instr_reg.b1;
    endcase
    // [RULE_21] pointer-mode destination
    if (op == OP_DIV) begin
      dst_addr = {instr_reg.b2[7:1], 1'b0};
    end else if (instr_reg.opc == OPC_WDEC_IND) begin
      dst_addr = {rf_reg[work_addr(bank_reg, instr_reg.b1[3:0])][7:1], 1'b0};
    end else begin
      dst_addr = {instr_reg.b1[7:1], 1'b0};
    end
    dst_lo   = dst_addr | 8'h01;
    // [RULE_01] even byte is the high half
    pair     = {rf_reg[dst_addr], rf_reg[dst_lo]};
    div_zero = (div_src == 8'h00);
  end

  wdx_word_minus_one_op #(.W(16)) u_word_minus_one_op (
    .word_in  (pair),
    .word_out (dec_word),
    .zero     (dec_z),
    .neg      (dec_s),
    .ovf      (dec_v)
  );

  wdx_div #(.DW(16), .VW(8)) u_div (
    .dividend (pair),
    .divisor  (div_src),
    .quot     (quot),
    .rem      (rem)
  );

  // [RULE_10] overflow and carry of the divide
  assign div_v = div_zero | (quot[15:8] != 8'h00);
  assign div_c = ~div_zero & (quot[15:9] == 7'h00) & quot[8];
  // [RULE_11] zero from divisor or quotient
  assign div_z = div_zero | (quot == 16'h0000);

  // cycle budget per instruction
  always_comb begin
    case (op)
      // [RULE_03] word decrement time
      OP_WDEC: n_cyc = CYC_WDEC;
      // [RULE_12] divide time depends on divisor
      OP_DIV: n_cyc = div_zero ? CYC_DIV_ZERO : CYC_DIV;
      // [RULE_17] same time taken or not
      OP_LOOP: n_cyc = CYC_LOOP;
      // [RULE_20] gate instructions are short
      OP_IRQ_OFF, OP_IRQ_ON: n_cyc = CYC_IRQ;
      default: n_cyc = CYC_BAD;
    endcase
  end

  // sequencer: exec counts down, commit is the last cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 5'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go_reg) begin
            cnt_reg   <= n_cyc - 5'h01;
            state_reg <= (n_cyc == 5'h01) ? ST_COMMIT : ST_EXEC;
          end
        end
        ST_EXEC: begin
          cnt_reg <= cnt_reg - 5'h01;
          if (cnt_reg == 5'h01) begin
            state_reg <= ST_COMMIT;
          end
        end
        ST_COMMIT: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // unknown opcodes do nothing but raise the status bit
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bad_reg <= 1'b0;
    end else if (go_reg && state_reg == ST_IDLE) begin
      bad_reg <= (op == OP_BAD);
    end
  end

  // register file; no reset, it is plain data storage
  always_ff @(posedge CLK) begin
    if (commit) begin
      case (op)
        OP_WDEC: begin
          rf_reg[dst_addr] <= dec_word[15:8];
          rf_reg[dst_lo]   <= dec_word[7:0];
        end
        // [RULE_09] remainder high, quotient low
        OP_DIV: begin
          if (!div_zero) begin
            rf_reg[dst_addr] <= rem;
            rf_reg[dst_lo]   <= quot[7:0];
          end
        end
        OP_LOOP: rf_reg[loop_addr] <= loop_val;
        default: ;
      endcase
    end else if (wr_sys && rf_hit(bus_addr_reg) && !busy) begin
      rf_reg[bus_addr_reg[9:2]] <= HWDATA[7:0];
    end
  end

  // flags; only decrement, divide and a bus write to ADDR_PC touch them
  // [RULE_07] gate and loop leave flags
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      flags_reg <= RST_FLAGS;
    end else if (commit && op == OP_WDEC) begin
      // [RULE_02] carry, decimal, half left alone
      flags_reg.z <= dec_z;
      flags_reg.s <= dec_s;
      flags_reg.v <= dec_v;
    end else if (commit && op == OP_DIV) begin
      // [RULE_11] sign from stored quotient msb
      flags_reg.c <= div_c;
      flags_reg.z <= div_z;
      flags_reg.s <= quot[7];
      flags_reg.v <= div_v;
    end else if (wr_sys && bus_addr_reg == ADDR_PC && !busy) begin
      flags_reg <= HWDATA[FLAGS_LSB +: 8];
    end
  end

  // program counter advance and loop branch
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pc_reg <= RST_PC;
    end else if (commit) begin
      case (op)
        OP_WDEC: pc_reg <= pc_reg + LEN_WDEC;
        OP_DIV: pc_reg <= pc_reg + LEN_DIV;
        // [RULE_15] signed offset from the next instruction
        OP_LOOP: pc_reg <= pc_reg + LEN_LOOP
                           + ((loop_val != 8'h00) ? {{8{instr_reg.b1[7]}}, instr_reg.b1}
                                                  : 16'h0000);
        OP_IRQ_OFF, OP_IRQ_ON: pc_reg <= pc_reg + LEN_IRQ;
        default: pc_reg <= pc_reg;
      endcase
    end else if (wr_sys && bus_addr_reg == ADDR_PC && !busy) begin
      pc_reg <= HWDATA[PC_LSB +: 16];
    end
  end

  // mode register: global gate bit and working bank
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_en_reg <= RST_IRQEN;
      bank_reg   <= RST_BANK;
    end else if (commit && op == OP_IRQ_OFF) begin
      // [RULE_05] gate closed
      irq_en_reg <= 1'b0;
    end else if (commit && op == OP_IRQ_ON) begin
      // [RULE_18] gate opened
      irq_en_reg <= 1'b1;
    end else if (wr_sys && bus_addr_reg == ADDR_MODE && !busy) begin
      irq_en_reg <= HWDATA[MODE_EN_BIT];
      bank_reg   <= HWDATA[MODE_BANK_LSB +: 8];
    end
  end

  // [RULE_06] requests latch regardless of the gate; set beats clear
  assign pend_clr = (wr_sys && bus_addr_reg == ADDR_PEND) ? HWDATA[NUM_IRQ-1:0] : '0;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~pend_clr) | IRQ_REQ;
    end
  end

  // [RULE_19] held requests go out as soon as the gate opens
  assign IRQ_SERVICE   = irq_en_reg & (|pend_reg);
  assign IRQ_GLOBAL_EN = irq_en_reg;
  assign BUSY          = busy;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_go(wdx_op_t k);
    go_reg && state_reg == ST_IDLE && op == k;
  endsequence
  sequence s_done(wdx_op_t k);
    commit && op == k;
  endsequence

  word_dec_time_a: assert property (s_go(OP_WDEC) |-> ##8 commit) // [RULE_03]
    else $error("word decrement not done in 8 cycles");
  word_dec_value_a: assert property (s_done(OP_WDEC) |=> // [RULE_01]
    {rf_reg[$past(dst_addr)], rf_reg[$past(dst_lo)]} == $past(pair) - 16'h0001)
    else $error("word decrement result wrong");
  word_dec_flags_a: assert property (s_done(OP_WDEC) |=> // [RULE_02]
    flags_reg.z == ($past(pair) == 16'h0001) && $stable(flags_reg.c)
    && $stable(flags_reg.d) && $stable(flags_reg.h))
    else $error("word decrement flags wrong");
  div_time_a: assert property (s_go(OP_DIV) and !div_zero |-> ##26 commit) // [RULE_12]
    else $error("divide not done in 26 cycles");
  div_zero_time_a: assert property (s_go(OP_DIV) and div_zero |-> ##10 commit) // [RULE_12]
    else $error("zero divide not done in 10 cycles");
  div_store_a: assert property (s_done(OP_DIV) and !div_zero |=> // [RULE_09]
    rf_reg[$past(dst_lo)] == 8'($past(pair) / $past(div_src))
    && rf_reg[$past(dst_addr)] == 8'($past(pair) % $past(div_src)))
    else $error("divide halves wrong");
  div_ovf_a: assert property (s_done(OP_DIV) |=> // [RULE_10]
    flags_reg.v == ($past(div_zero) || $past(quot) >= 16'h0100))
    else $error("divide overflow flag wrong");
  gate_off_a: assert property (s_go(OP_IRQ_OFF) |-> ##4 commit ##1 !irq_en_reg) // [RULE_05]
    else $error("gate not closed after 4 cycles");
  gate_on_a: assert property (s_go(OP_IRQ_ON) |-> ##4 commit ##1 irq_en_reg) // [RULE_20]
    else $error("gate not opened after 4 cycles");
  flags_hold_a: assert property (commit && op inside {OP_IRQ_OFF, OP_IRQ_ON, OP_LOOP} // [RULE_07]
    |=> $stable(flags_reg))
    else $error("flags moved on gate or loop");
  loop_time_a: assert property (s_go(OP_LOOP) |-> ##8 commit) // [RULE_17]
    else $error("loop not done in 8 cycles");
  loop_pc_a: assert property (s_done(OP_LOOP) |=> pc_reg == $past(pc_reg) + 16'h0002 // [RULE_14]
    + (($past(loop_val) != 8'h00) ? {{8{$past(instr_reg.b1[7])}}, $past(instr_reg.b1)} : 16'h0000))
    else $error("loop branch target wrong");
  pend_set_a: assert property (IRQ_REQ != '0 |=> // [RULE_06]
    (pend_reg & $past(IRQ_REQ)) == $past(IRQ_REQ))
    else $error("request lost from pending");
  held_service_a: assert property (pend_reg != '0 && !irq_en_reg ##1 $rose(irq_en_reg) // [RULE_19]
    |-> IRQ_SERVICE)
    else $error("held request not serviced on enable");
endmodule : wdx_core
`default_nettype wire

// file: rtl/wdx_div.sv
// combinational restoring divider, full-width quotient for range checks
`timescale 1ns/1ps
`default_nettype none
module wdx_div #(
  parameter int DW = 16,
  parameter int VW = 8
) (
  // operands
  input  wire logic [DW-1:0] dividend,
  input  wire logic [VW-1:0] divisor,
  // results
  output logic      [DW-1:0] quot,
  output logic      [VW-1:0] rem
);
  logic [VW-1:0] part [0:DW];
  assign part[0] = '0;
  // one subtract-and-restore stage per dividend bit, msb first
  for (genvar i = 0; i < DW; i++) begin : g_step
    logic [VW:0]   shifted;
    logic [VW+1:0] trial;
    assign shifted        = {part[i], dividend[DW-1-i]};
    assign trial          = {1'b0, shifted} - {2'b00, divisor};
    assign quot[DW-1-i]   = ~trial[VW+1];
    assign part[i+1]      = trial[VW+1] ? shifted[VW-1:0] : trial[VW-1:0];
  end
  // zero divisor gives all-ones quotient; caller flags it
  assign rem = part[DW];
endmodule : wdx_div
`default_nettype wire

// file: rtl/wdx_pkg.sv
// shared constants, types and decode helpers for the executor
package wdx_pkg;
  // opcodes
  localparam logic [7:0] OPC_WDEC_PAIR = 8'h80;
  localparam logic [7:0] OPC_WDEC_IND  = 8'h81;
  localparam logic [7:0] OPC_DIV_REG   = 8'h94;
  localparam logic [7:0] OPC_DIV_IND   = 8'h95;
  localparam logic [7:0] OPC_DIV_IMM   = 8'h96;
  localparam logic [7:0] OPC_IRQ_OFF   = 8'h8f;
  localparam logic [7:0] OPC_IRQ_ON    = 8'h9f;
  localparam logic [3:0] OPC_LOOP_LO   = 4'ha;
  // execution cycle counts
  localparam logic [4:0] CYC_WDEC      = 5'h08;
  localparam logic [4:0] CYC_DIV       = 5'h1a;
  localparam logic [4:0] CYC_DIV_ZERO  = 5'h0a;
  localparam logic [4:0] CYC_LOOP      = 5'h08;
  localparam logic [4:0] CYC_IRQ       = 5'h04;
  localparam logic [4:0] CYC_BAD       = 5'h01;
  // instruction lengths in bytes
  localparam logic [15:0] LEN_WDEC     = 16'h0002;
  localparam logic [15:0] LEN_DIV      = 16'h0003;
  localparam logic [15:0] LEN_LOOP     = 16'h0002;
  localparam logic [15:0] LEN_IRQ      = 16'h0001;
  // bus map (byte addresses)
  localparam logic [11:0] ADDR_INSTR   = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_MODE    = 12'h008;
  localparam logic [11:0] ADDR_PC      = 12'h00c;
  localparam logic [11:0] ADDR_PEND    = 12'h010;
  localparam logic [1:0]  RF_WIN_TAG   = 2'h1;
  localparam int          RF_DEPTH     = 256;
  // field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BAD_BIT  = 1;
  localparam int MODE_EN_BIT   = 0;
  localparam int MODE_BANK_LSB = 8;
  localparam int PC_LSB        = 0;
  localparam int FLAGS_LSB     = 16;
  // reset values
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [7:0]  RST_BANK  = 8'h00;
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic        RST_IRQEN = 1'b0;
  // condition flags, zero flag sits at bit 6
  typedef struct packed {
    logic c; logic z; logic s; logic v; logic d; logic h; logic [1:0] rsv;
  } wdx_flags_t;
  typedef struct packed {logic [7:0] b2; logic [7:0] b1; logic [7:0] opc;} wdx_instr_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_COMMIT = 2'b11} wdx_state_t;
  typedef enum logic [2:0] {
    OP_WDEC, OP_DIV, OP_LOOP, OP_IRQ_OFF, OP_IRQ_ON, OP_BAD
  } wdx_op_t;

  function automatic wdx_op_t op_class(input logic [7:0] opc);
    case (opc)
      OPC_WDEC_PAIR, OPC_WDEC_IND: op_class = OP_WDEC;
      OPC_DIV_REG, OPC_DIV_IND, OPC_DIV_IMM: op_class = OP_DIV;
      OPC_IRQ_OFF: op_class = OP_IRQ_OFF;
      OPC_IRQ_ON: op_class = OP_IRQ_ON;
      default: op_class = (opc[3:0] == OPC_LOOP_LO) ? OP_LOOP : OP_BAD;
    endcase
  endfunction : op_class

  // register-file address of a working register
  function automatic logic [7:0] work_addr(input logic [7:0] bank, input logic [3:0] r);
    work_addr = {bank[7:4], r};
  endfunction : work_addr
endpackage : wdx_pkg

// file: rtl/wdx_word_minus_one_op.sv
// sixteen-bit decrement with zero, sign and overflow outputs
`timescale 1ns/1ps
`default_nettype none
module wdx_word_minus_one_op #(
  parameter int W = 16
) (
  // operand
  input  wire logic [W-1:0] word_in,
  // result and flags
  output logic      [W-1:0] word_out,
  output logic              zero,
  output logic              neg,
  output logic              ovf
);
  // subtract one across the whole word, borrow crosses the byte seam
  assign word_out = word_in - W'(1);
  assign zero     = (word_out == '0);
  assign neg      = word_out[W-1];
  // only the most negative value overflows when one is taken away
  assign ovf      = (word_in == {1'b1, {(W-1){1'b0}}});
endmodule : wdx_word_minus_one_op
`default_nettype wire

// file: verif/wdx_tb.sv
// self-checking bench for the word, divide, loop and irq executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  import wdx_pkg::*;
  logic        CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP;
  logic        IRQ_SERVICE, IRQ_GLOBAL_EN, BUSY, in_rd;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS;
  logic [7:0]  IRQ_REQ, fl, fm, dsp, dop [6], dv [6];
  logic [15:0] pc, r, q, rm, wv [4], dd [6];
  logic [2:0]  k;
  logic [75:0] exq [$];
  int          err_count, checked;

  wdx_core #(.NUM_IRQ(8)) u_dut (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .IRQ_REQ(IRQ_REQ),
    .IRQ_SERVICE(IRQ_SERVICE), .IRQ_GLOBAL_EN(IRQ_GLOBAL_EN), .BUSY(BUSY));

  // 50 MHz clock
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic give_verdict;
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // bounded wait for hready; running out counts as a mismatch
  task automatic rdy;
    int n;
    n = 0;
    do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 64);
    if (n >= 64) begin err_count++; give_verdict(); end
  endtask : rdy

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    HSEL <= 1'b1; HTRANS <= 2'b10; HADDR <= {20'h0, a}; HWRITE <= w;
    rdy();
    HTRANS <= 2'b00; HWDATA <= d;
    if (!w) in_rd <= 1'b1;
    rdy();
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  // note the expectation, then read; the watcher compares
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exq.push_back({a, m, e});
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic rw(input logic [7:0] i, input logic [7:0] v);
    wr(12'h400 + {2'b0, i, 2'b0}, {24'h0, v});
  endtask : rw

  task automatic rf_chk(input logic [7:0] i, input logic [7:0] v);
    rd(12'h400 + {2'b0, i, 2'b0}, {24'h0, v}, 32'hff);
  endtask : rf_chk

  task automatic chkpf(input logic [7:0] m);
    rd(ADDR_PC, {8'h0, fl, pc}, {8'h0, m, 16'hffff});
  endtask : chkpf

  // run one instruction and count its busy cycles (go cycle through commit)
  task automatic ex(input logic [23:0] ins, input int n);
    int c;
    c = 0;
    wr(ADDR_INSTR, {8'h0, ins});
    for (int j = 0; j < 40; j++) begin
      @(posedge CLK);
      if (BUSY === 1'b1) c++;
      else if (c > 0) break;
    end
    `CHK("cycles", n + 1, c)
  endtask : ex

  // watcher: read data is taken at the edge that ends the data phase
  always @(posedge CLK) begin
    if (in_rd === 1'b1 && HREADYOUT === 1'b1 && exq.size() > 0) begin
      in_rd <= 1'b0;
      `CHK($sformatf("read %h", exq[0][75:64]), exq[0][31:0], HRDATA & exq[0][63:32])
      `CHK("hresp", 1'b0, HRESP)
      void'(exq.pop_front());
    end
  end

  initial begin
    HSEL = 0; HTRANS = 0; HADDR = 0; HWRITE = 0; HWDATA = 0; IRQ_REQ = 0; in_rd = 0;
    err_count = 0; checked = 0; RST_B = 0;
    void'($urandom(32'h63a8b621));
    wv = '{16'h1234, 16'h8000, 16'h0001, 16'h0};
    wv[3] = 16'($urandom);
    dd = '{16'h1003, 16'h1003, 16'h1003, 16'h0005, 16'h1234, 16'h0};
    dv = '{8'h40, 8'h20, 8'h10, 8'h40, 8'h00, 8'h0};
    dop = '{OPC_DIV_REG, OPC_DIV_IMM, OPC_DIV_IND, OPC_DIV_IND, OPC_DIV_REG, OPC_DIV_IMM};
    dd[5] = 16'($urandom);
    dv[5] = 8'($urandom);
    k = 3'($urandom);
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd(ADDR_STATUS, 32'h0, 32'h3);
    rd(ADDR_PC, 32'h0, 32'h00fcffff);
    rd(ADDR_PEND, 32'h0, 32'hff);
    // preset carry, decimal and half so that keeping them is visible
    pc = 16'h0100;
    fl = 8'h8c;
    wr(ADDR_PC, {8'h0, fl, pc});
    for (int i = 0; i < 4; i++) begin
      rw(8'h10, wv[i][15:8]);
      rw(8'h11, wv[i][7:0]);
      ex({8'h00, 8'h10, OPC_WDEC_PAIR}, 8);
      r = wv[i] - 16'h1;
      pc += LEN_WDEC;
      fl[6:4] = {r == 16'h0, r[15], wv[i] == 16'h8000};
      // both bytes read back, so zero is tested by their OR
      rf_chk(8'h10, r[15:8]);
      rf_chk(8'h11, r[7:0]);
      chkpf(8'hfc);
    end
    // pointer in working reg 2 is odd; the low bit must be dropped
    rw(8'h02, 8'h31);
    rw(8'h30, 8'h0f);
    rw(8'h31, 8'h21);
    ex({8'h00, 8'h02, OPC_WDEC_IND}, 8);
    pc += LEN_WDEC;
    fl[6:4] = 3'b000;
    rf_chk(8'h31, 8'h20);
    rf_chk(8'h30, 8'h0f);
    chkpf(8'hfc);
    for (int i = 0; i < 6; i++) begin
      rw(8'h40, dv[i]);
      rw(8'h42, 8'h40);
      rw(8'h20, dd[i][15:8]);
      rw(8'h21, dd[i][7:0]);
      dsp = (dop[i] == OPC_DIV_REG) ? 8'h40 : (dop[i] == OPC_DIV_IND) ? 8'h42 : dv[i];
      ex({8'h20, dsp, dop[i]}, (dv[i] == 8'h0) ? 10 : 26);
      pc += LEN_DIV;
      fm = 8'hfc;
      if (dv[i] == 8'h0) begin
        fl[6] = 1'b1;
        fl[4] = 1'b1;
        fm = 8'h5c;
      end else begin
        q = dd[i] / dv[i];
        rm = dd[i] % dv[i];
        fl[7:4] = {q >= 16'h100 && q < 16'h200, q == 16'h0, q[7], q >= 16'h100};
        if (q < 16'h100) rf_chk(8'h20, rm[7:0]);
        if (q < 16'h100) rf_chk(8'h21, q[7:0]);
      end
      chkpf(fm);
    end
    // flags after a zero divisor are partly open; put back a known state
    wr(ADDR_PC, {8'h0, fl, pc});
    wr(ADDR_MODE, 32'h0000c000);
    rw(8'hc1, 8'h03);
    for (int i = 0; i < 3; i++) begin
      dsp = (i == 1) ? 8'h80 : 8'h7f;
      ex({8'h00, dsp, 4'h1, OPC_LOOP_LO}, 8);
      pc = pc + LEN_LOOP + ((i < 2) ? {{8{dsp[7]}}, dsp} : 16'h0);
      rf_chk(8'hc1, 8'(2 - i));
      chkpf(8'hfc);
    end
    ex({16'h0, OPC_IRQ_OFF}, 4);
    pc += LEN_IRQ;
    IRQ_REQ <= 8'h1 << k;
    @(posedge CLK);
    IRQ_REQ <= 8'h0;
    @(posedge CLK);
    `CHK("service", 1'b0, IRQ_SERVICE)
    rd(ADDR_PEND, {24'h0, 8'h1 << k}, 32'hff);
    ex({16'h0, OPC_IRQ_ON}, 4);
    pc += LEN_IRQ;
    `CHK("service", 1'b1, IRQ_SERVICE)
    `CHK("irq_en", 1'b1, IRQ_GLOBAL_EN)
    rd(ADDR_MODE, 32'h1, 32'h1);
    chkpf(8'hfc);
    ex({16'h0, OPC_IRQ_OFF}, 4);
    pc += LEN_IRQ;
    `CHK("irq_en", 1'b0, IRQ_GLOBAL_EN)
    rd(ADDR_MODE, 32'h0, 32'h1);
    // gate is shut before the pending bits are touched
    wr(ADDR_PEND, 32'hff);
    @(posedge CLK);
    `CHK("service", 1'b0, IRQ_SERVICE)
    rd(ADDR_PEND, 32'h0, 32'hff);
    // unknown opcode: refused, pc kept, bad flag shown
    ex(24'h0, 1);
    rd(ADDR_STATUS, 32'h2, 32'h3);
    chkpf(8'hfc);
    rd(12'h014, 32'h0, 32'hffffffff);
    @(posedge CLK);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
